// [flash_wp_pkg.sv]
// Purpose: Shared constants and types for the flash write-protection block
// Assumes: 20 MHz system clock, 4 MB array in 4 KB sectors
// Notes: Opcodes are the serial command codes the host sends
package flash_wp_pkg;

    // Clock and timing
    localparam int CLK_MHZ = 20;
    localparam int SELECT_WAIT_US = 70;
    localparam int SELECT_WAIT_CYC = SELECT_WAIT_US * CLK_MHZ;
    localparam int CNT_W = 11;
    // Cycles allowed for the last byte event to cross before frame end is judged
    localparam logic [1:0] END_SETTLE_CYC = 2'h3;

    // Array geometry in 4 KB sector units
    localparam int SEC_W = 10;
    localparam int BLOCK_COUNT = 64;
    localparam int BLK_W = 6;
    localparam int SEC_LSB = 12;
    localparam int BLK_LSB = 16;
    localparam logic [SEC_W-1:0] FINE_CAP = 10'h008;
    localparam logic [SEC_W-1:0] COARSE_UNIT = 10'h010;
    localparam logic [SEC_W-1:0] SEC_MAX = 10'h3ff;
    localparam logic [SEC_W-1:0] BLK32_MASK = 10'h007;
    localparam logic [SEC_W-1:0] BLK64_MASK = 10'h00f;

    // Register reset values
    localparam logic [7:0] STATUS_LO_RESET = 8'h00;
    localparam logic [7:0] STATUS_HI_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h40;

    // Field positions
    localparam int BUSY_BIT = 0;
    localparam int WEL_BIT = 1;
    localparam int BP_LSB = 2;
    localparam int SRP0_BIT = 7;
    localparam int SRP1_BIT = 0;
    localparam int CMP_BIT = 6;
    localparam int WPS_BIT = 2;

    // Command codes
    localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_WRITE_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_WRITE_CONFIG = 8'h11;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
    localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'hc7;
    localparam logic [7:0] OP_DEEP_DOWN = 8'hb9;
    localparam logic [7:0] OP_DEEP_RELEASE = 8'hab;
    localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;
    localparam logic [7:0] OP_BLOCK_UNLOCK = 8'h39;

    typedef enum logic [1:0] {
        KIND_PROGRAM,
        KIND_ERASE
    } array_kind_t;

    typedef enum {
        ST_POWERUP,
        ST_STANDBY,
        ST_BUSY,
        ST_DEEP
    } ctrl_state_t;

endpackage

// [byte_link_if.sv]
`timescale 1ns/1ns
// Purpose: Carries captured serial bytes from the link domain to the system domain
// Assumes: byte_data is stable for eight serial clocks after each toggle
// Notes: byte_toggle flips once per completed byte
interface byte_link_if;
    logic [7:0] byte_data;
    logic byte_toggle;
    logic mid_byte;

    modport capture (output byte_data, output byte_toggle, output mid_byte);
    modport consumer (input byte_data, input byte_toggle, input mid_byte);
endinterface

// [serial_byte_capture.sv]
`timescale 1ns/1ns
// Purpose: Shifts serial input bits into bytes on the serial clock
// Assumes: Data sampled on rising sclk, most significant bit first
// Notes: cs_n high clears the bit position asynchronously
module serial_byte_capture
(
    // Link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    // Reset from the system side, applied asynchronously
    input wire logic link_rst,
    // Toward the system domain
    byte_link_if.capture lnk
);
    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic [7:0] byte_q;
    logic tog_q;
    logic mid_q;

    // Bit position restarts at every frame
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_q <= 3'h0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge sclk) begin
        shift_q <= {shift_q[5:0], si};
        if (bit_cnt_q == 3'h7) begin
            byte_q <= {shift_q, si};
        end
    end

    // Survives the frame end so the last byte and the trailing-bit flag still cross
    always_ff @(posedge sclk or posedge link_rst) begin
        if (link_rst) begin
            tog_q <= 1'b0;
            mid_q <= 1'b0;
        end else begin
            mid_q <= (bit_cnt_q != 3'h7);
            if (bit_cnt_q == 3'h7) begin
                tog_q <= ~tog_q;
            end
        end
    end

    assign lnk.byte_data = byte_q;
    assign lnk.byte_toggle = tog_q;
    assign lnk.mid_byte = mid_q;
endmodule

// [protect_check.sv]
`timescale 1ns/1ns
// Purpose: Decides whether a sector range touches protected memory
// Assumes: Ranges are inclusive, in 4 KB sector units
// Notes: Purely combinational
module protect_check
    import flash_wp_pkg::*;
(
    // Protection settings
    input wire logic [4:0] range_bits,
    input wire logic invert,
    input wire logic per_block,
    input wire logic [BLOCK_COUNT-1:0] locks,
    // Target region
    input wire logic [SEC_W-1:0] reg_lo,
    input wire logic [SEC_W-1:0] reg_hi,
    // Result
    output logic hit
);
    wire [2:0] n = range_bits[2:0];
    wire [2:0] sh = n - 3'h1;
    wire none_base = (n == 3'h0);
    wire all_base = (n == 3'h7);
    wire bottom = range_bits[3];
    wire [SEC_W-1:0] fine_span = (n >= 3'h4) ? FINE_CAP : (SEC_W'(1) << sh);
    wire [SEC_W-1:0] coarse_span = COARSE_UNIT << sh;
    wire [SEC_W-1:0] span = range_bits[4] ? fine_span : coarse_span;
    wire [SEC_W-1:0] top_start = SEC_W'(~span + 10'h001);
    wire full = invert ? none_base : all_base;
    wire enabled = invert ? !all_base : !none_base;
    wire [SEC_W-1:0] base_lo = bottom ? '0 : top_start;
    wire [SEC_W-1:0] base_hi = bottom ? span - 10'h001 : SEC_MAX;
    wire [SEC_W-1:0] inv_lo = bottom ? span : '0;
    wire [SEC_W-1:0] inv_hi = bottom ? SEC_MAX : top_start - 10'h001;
    wire [SEC_W-1:0] prot_lo = full ? '0 : (invert ? inv_lo : base_lo);
    wire [SEC_W-1:0] prot_hi = full ? SEC_MAX : (invert ? inv_hi : base_hi);
    wire range_hit = enabled && (reg_lo <= prot_hi) && (reg_hi >= prot_lo);
    wire [BLK_W-1:0] blk_lo = reg_lo[SEC_W-1:SEC_W-BLK_W];
    wire [BLK_W-1:0] blk_hi = reg_hi[SEC_W-1:SEC_W-BLK_W];
    logic [BLOCK_COUNT-1:0] blk_sel;

    for (genvar b = 0; b < BLOCK_COUNT; b++) begin : g_blk
        assign blk_sel[b] = locks[b] && (BLK_W'(b) >= blk_lo) && (BLK_W'(b) <= blk_hi);
    end

    assign hit = per_block ? |blk_sel : range_hit;
endmodule

// [flash_write_protection.sv]
// Purpose: Write-protection and power-up safety logic of a serial flash
// Assumes: Host drives sclk, cs_n, si; array sequencer answers on clk
// Notes: Command bytes cross from sclk into clk by toggle and hold register
// Functional notes
// - Registers start at 00h, 00h, 40h.
// - Controller enters standby after power-up.
// - Only complete accepted commands change contents.
// - Data-changing commands must end on byte boundary.
// - Data changes need the write latch set.
// - Write-protect pin low freezes range and lock bits.
// - Deep power-down ignores all but release.
// - Range field decodes to top or bottom units.
// - Invert bit protects the complementary range.
// - Writes touching protected addresses are dropped.
// - Per-block select uses individual lock bits.
// - All block locks are set after power-up.
`timescale 1ns/1ns
module flash_write_protection
    import flash_wp_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic srst,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    // Write-protect pin
    input wire logic wp_n,
    // Array sequencer
    input wire logic array_done,
    output logic array_start_q,
    output array_kind_t array_kind_q,
    output logic [SEC_W-1:0] array_lo_q,
    output logic [SEC_W-1:0] array_hi_q,
    // Command results
    output logic cmd_accept_q,
    output logic cmd_reject_q,
    // Register contents and state
    output logic [7:0] status_lo_q,
    output logic [7:0] status_hi_q,
    output logic [7:0] config_q,
    output logic [BLOCK_COUNT-1:0] lock_bits_q,
    output logic select_ready_q,
    output logic deep_power_down_q
);
    byte_link_if lnk ();

    ctrl_state_t state_q, state_d;
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic cs_prev_q;
    logic seen_tog_q;
    logic [2:0] byte_cnt_q;
    logic [7:0] opcode_q;
    logic [23:0] addr_q;
    logic [7:0] dat0_q;
    logic [7:0] dat1_q;
    logic end_pend_q;
    logic [1:0] end_wait_q;
    logic [CNT_W-1:0] wait_cnt_q;
    logic write_latch_flag_q;
    logic [4:0] protect_range_bits_q;
    logic protect_invert_bit_q;
    logic [1:0] status_lock_bits_q;
    logic per_block_select_bit_q;
    logic output_drive_strength_bit_q;
    logic [7:0] cfg_other_q;
    logic prot_hit;

    serial_byte_capture u_capture (
        .sclk(sclk),
        .cs_n(cs_n),
        .si(si),
        .link_rst(srst),
        .lnk(lnk.capture)
    );

    // Synchronisers: only sync_q is read by logic
    wire [3:0] async_in = {wp_n, lnk.mid_byte, lnk.byte_toggle, cs_n};
    wire cs_sync = sync_q[0];
    wire tog_sync = sync_q[1];
    wire mid_sync = sync_q[2];
    wire wp_n_sync = sync_q[3];

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= 4'h9;
            sync_q <= 4'h9;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    // Frame and byte events
    wire frame_open = cs_prev_q && !cs_sync;
    wire frame_close = !cs_prev_q && cs_sync;
    wire byte_evt = (tog_sync != seen_tog_q);
    // A late byte restarts the settle wait so frame end sees every byte
    wire end_ready = end_pend_q && !byte_evt && (end_wait_q == END_SETTLE_CYC);

    always_ff @(posedge clk) begin
        if (srst) begin
            cs_prev_q <= 1'b1;
            seen_tog_q <= 1'b0;
            end_pend_q <= 1'b0;
            end_wait_q <= 2'h0;
        end else begin
            cs_prev_q <= cs_sync;
            seen_tog_q <= tog_sync;
            if (frame_close) begin
                end_pend_q <= 1'b1;
                end_wait_q <= 2'h0;
            end else if (end_ready || frame_open) begin
                end_pend_q <= 1'b0;
            end else if (end_pend_q) begin
                end_wait_q <= byte_evt ? 2'h0 : end_wait_q + 2'h1;
            end
        end
    end

    // Byte collection; count saturates so long programs stay valid
    always_ff @(posedge clk) begin
        if (srst || frame_open) begin
            byte_cnt_q <= 3'h0;
            opcode_q <= 8'h00;
            addr_q <= 24'h000000;
            dat0_q <= 8'h00;
            dat1_q <= 8'h00;
        end else if (byte_evt) begin
            if (byte_cnt_q != 3'h7) begin
                byte_cnt_q <= byte_cnt_q + 3'h1;
            end
            if (byte_cnt_q == 3'h0) begin
                opcode_q <= lnk.byte_data;
            end
            if (byte_cnt_q >= 3'h1 && byte_cnt_q <= 3'h3) begin
                addr_q <= {addr_q[15:0], lnk.byte_data};
            end
            if (byte_cnt_q == 3'h1) begin
                dat0_q <= lnk.byte_data;
            end
            if (byte_cnt_q == 3'h2) begin
                dat1_q <= lnk.byte_data;
            end
        end
    end

    // Command decode
    wire len_one = (byte_cnt_q == 3'h1);
    wire len_addr = (byte_cnt_q == 3'h4);
    wire len_prog = (byte_cnt_q >= 3'h5);
    wire whole_bytes = !mid_sync && (byte_cnt_q != 3'h0);
    wire op_set = (opcode_q == OP_WRITE_LATCH_SET) && len_one;
    wire op_clr = (opcode_q == OP_WRITE_LATCH_CLR) && len_one;
    wire op_down = (opcode_q == OP_DEEP_DOWN) && len_one;
    wire op_release = (opcode_q == OP_DEEP_RELEASE) && len_one;
    wire op_wrsr = (opcode_q == OP_WRITE_STATUS) && (byte_cnt_q == 3'h2 || byte_cnt_q == 3'h3);
    wire op_wrcr = (opcode_q == OP_WRITE_CONFIG) && (byte_cnt_q == 3'h2);
    wire op_prog = (opcode_q == OP_PAGE_PROGRAM) && len_prog;
    wire op_sec = (opcode_q == OP_SECTOR_ERASE) && len_addr;
    wire op_b32 = (opcode_q == OP_BLOCK32_ERASE) && len_addr;
    wire op_b64 = (opcode_q == OP_BLOCK64_ERASE) && len_addr;
    wire op_chip = (opcode_q == OP_CHIP_ERASE || opcode_q == OP_CHIP_ERASE_ALT) && len_one;
    wire op_lock = (opcode_q == OP_BLOCK_LOCK) && len_addr;
    wire op_unlock = (opcode_q == OP_BLOCK_UNLOCK) && len_addr;
    wire op_array = op_prog || op_sec || op_b32 || op_b64 || op_chip;
    wire op_regs = op_wrsr || op_wrcr || op_lock || op_unlock;

    // Target region in sectors
    wire [SEC_W-1:0] sector = addr_q[SEC_LSB+SEC_W-1:SEC_LSB];
    wire [BLK_W-1:0] block_idx = addr_q[BLK_LSB+BLK_W-1:BLK_LSB];
    wire [SEC_W-1:0] reg_lo = op_chip ? '0 :
                              op_b64 ? (sector & ~BLK64_MASK) :
                              op_b32 ? (sector & ~BLK32_MASK) : sector;
    wire [SEC_W-1:0] reg_hi = op_chip ? SEC_MAX :
                              op_b64 ? (sector | BLK64_MASK) :
                              op_b32 ? (sector | BLK32_MASK) : sector;

    protect_check u_check (
        .range_bits(protect_range_bits_q),
        .invert(protect_invert_bit_q),
        .per_block(per_block_select_bit_q),
        .locks(lock_bits_q),
        .reg_lo(reg_lo),
        .reg_hi(reg_hi),
        .hit(prot_hit)
    );

    // Judgement at frame end
    wire exec = end_ready && whole_bytes;
    wire in_standby = (state_q == ST_STANDBY);
    wire in_deep = (state_q == ST_DEEP);
    wire wants_latch = op_array || op_regs;
    wire latch_ok = write_latch_flag_q || !wants_latch;
    wire array_ok = op_array && !prot_hit;
    wire known = op_set || op_clr || op_down || op_regs || array_ok;
    wire do_cmd = exec && in_standby && latch_ok && known;
    wire do_release = exec && in_deep && op_release;
    wire refuse = end_ready && !do_cmd && !do_release;
    wire wp_low = !wp_n_sync;

    // Controller state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_POWERUP: begin
                if (wait_cnt_q == CNT_W'(SELECT_WAIT_CYC - 1)) begin
                    state_d = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (do_cmd && op_down) begin
                    state_d = ST_DEEP;
                end else if (do_cmd && op_array) begin
                    state_d = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (array_done) begin
                    state_d = ST_STANDBY;
                end
            end
            ST_DEEP: begin
                if (do_release) begin
                    state_d = ST_STANDBY;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_POWERUP;
            wait_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_POWERUP) begin
                wait_cnt_q <= wait_cnt_q + CNT_W'(1);
            end
        end
    end

    // Write latch: a set in the same frame outranks everything else, so no race
    always_ff @(posedge clk) begin
        if (srst) begin
            write_latch_flag_q <= 1'b0;
        end else if (do_cmd) begin
            if (op_set) begin
                write_latch_flag_q <= 1'b1;
            end else if (op_clr || wants_latch) begin
                write_latch_flag_q <= 1'b0;
            end
        end
    end

    // Status and configuration fields
    always_ff @(posedge clk) begin
        if (srst) begin
            protect_range_bits_q <= STATUS_LO_RESET[BP_LSB+4:BP_LSB];
            status_lock_bits_q <= {STATUS_HI_RESET[SRP1_BIT], STATUS_LO_RESET[SRP0_BIT]};
            protect_invert_bit_q <= STATUS_HI_RESET[CMP_BIT];
            per_block_select_bit_q <= CONFIG_RESET[WPS_BIT];
            output_drive_strength_bit_q <= CONFIG_RESET[6];
            cfg_other_q <= CONFIG_RESET & 8'hbb;
        end else if (do_cmd) begin
            if (op_wrsr && !wp_low) begin
                protect_range_bits_q <= dat0_q[BP_LSB+4:BP_LSB];
                status_lock_bits_q[0] <= dat0_q[SRP0_BIT];
                if (byte_cnt_q == 3'h3) begin
                    status_lock_bits_q[1] <= dat1_q[SRP1_BIT];
                end
            end
            if (op_wrsr && byte_cnt_q == 3'h3) begin
                protect_invert_bit_q <= dat1_q[CMP_BIT];
            end
            if (op_wrcr) begin
                per_block_select_bit_q <= dat0_q[WPS_BIT];
                output_drive_strength_bit_q <= dat0_q[6];
                cfg_other_q <= dat0_q & 8'hbb;
            end
        end
    end

    // Individual block locks
    always_ff @(posedge clk) begin
        if (srst) begin
            lock_bits_q <= '1;
        end else if (do_cmd && (op_lock || op_unlock)) begin
            lock_bits_q[block_idx] <= op_lock;
        end
    end

    // Array start and command outcome pulses
    always_ff @(posedge clk) begin
        if (srst) begin
            array_start_q <= 1'b0;
            array_kind_q <= KIND_PROGRAM;
            array_lo_q <= '0;
            array_hi_q <= '0;
            cmd_accept_q <= 1'b0;
            cmd_reject_q <= 1'b0;
        end else begin
            array_start_q <= do_cmd && op_array;
            cmd_accept_q <= do_cmd || do_release;
            cmd_reject_q <= refuse;
            if (do_cmd && op_array) begin
                array_kind_q <= op_prog ? KIND_PROGRAM : KIND_ERASE;
                array_lo_q <= reg_lo;
                array_hi_q <= reg_hi;
            end
        end
    end

    // Register images
    always_ff @(posedge clk) begin
        if (srst) begin
            status_lo_q <= STATUS_LO_RESET;
            status_hi_q <= STATUS_HI_RESET;
            config_q <= CONFIG_RESET;
            select_ready_q <= 1'b0;
            deep_power_down_q <= 1'b0;
        end else begin
            status_lo_q <= {status_lock_bits_q[0], protect_range_bits_q, write_latch_flag_q,
                            state_q == ST_BUSY};
            status_hi_q <= {1'b0, protect_invert_bit_q, 5'h00, status_lock_bits_q[1]};
            config_q <= cfg_other_q | {1'b0, output_drive_strength_bit_q, 3'h0,
                                       per_block_select_bit_q, 2'h0};
            select_ready_q <= (state_q != ST_POWERUP);
            deep_power_down_q <= in_deep;
        end
    end
endmodule

// [flash_write_protection_monitor.sv]
// Purpose: Port-level checks of the flash write-protection block
// Assumes: Only the system clock domain is observed
// Notes: Bound from the testbench top file
`timescale 1ns/1ns
module flash_write_protection_monitor
    import flash_wp_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic srst,
    input wire logic wp_n,
    // Results and images
    input wire logic array_start_q,
    input wire logic cmd_accept_q,
    input wire logic cmd_reject_q,
    input wire logic [7:0] status_lo_q,
    input wire logic [7:0] status_hi_q,
    input wire logic [7:0] config_q,
    input wire logic [BLOCK_COUNT-1:0] lock_bits_q,
    input wire logic select_ready_q,
    input wire logic deep_power_down_q
);
    // Saturates so a long run never wraps back below the wait
    logic [CNT_W-1:0] up_q;
    always_ff @(posedge clk) begin
        if (srst)
            up_q <= '0;
        else if (up_q != '1)
            up_q <= up_q + 1'b1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    reset_values_a: assert property (disable iff (1'b0)
        srst |=> status_lo_q == 8'h00 && status_hi_q == 8'h00 && config_q == 8'h40
        && lock_bits_q == '1 && !select_ready_q && !deep_power_down_q)
        else $error("register images not at reset values");
    ready_late_a: assert property (select_ready_q |-> up_q >= SELECT_WAIT_CYC)
        else $error("select ready before power-up wait");
    ready_on_time_a: assert property (
        up_q == SELECT_WAIT_CYC + 10 |-> select_ready_q)
        else $error("standby not reached after power-up wait");
    early_accept_a: assert property (!select_ready_q |-> !cmd_accept_q)
        else $error("command accepted during power-up");
    one_verdict_a: assert property (!(cmd_accept_q && cmd_reject_q))
        else $error("frame both accepted and refused");
    start_accept_a: assert property (
        array_start_q |-> cmd_accept_q && !deep_power_down_q)
        else $error("array start without accepted frame");
    start_latch_a: assert property (
        array_start_q |-> $past(status_lo_q[WEL_BIT])
        ##1 (status_lo_q[BUSY_BIT] && !status_lo_q[WEL_BIT]))
        else $error("array start without write latch");
    wp_freeze_a: assert property (
        !wp_n && !$past(wp_n) && !$past(wp_n, 2) && !$past(wp_n, 3)
        |-> $stable(status_lo_q[7:2]) && $stable(status_hi_q[0]))
        else $error("protect bits changed with pin low");
    deep_quiet_a: assert property (
        deep_power_down_q && $past(deep_power_down_q)
        |-> $stable(status_lo_q) && $stable(config_q) && $stable(lock_bits_q))
        else $error("state changed in deep power-down");
endmodule

// [spi_host_model.sv]
// Purpose: Serial host that frames commands for the write-protection block
// Assumes: Mode 0, most significant bit first, 80 ns serial clock
// Notes: sclk stands still outside frames
`timescale 1ns/1ns
module spi_host_model
(
    // Serial link
    output logic sclk,
    output logic cs_n,
    output logic si
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // Bits are left-justified in d; a count off a byte edge is a deliberate fault
    task automatic send(input logic [39:0] d, input int nbits);
        int i;
        #7;
        cs_n = 1'b0;
        // Leaves the device time to see the select fall first
        #250;
        for (i = 0; i < nbits; i++) begin
            si = d[39-i];
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
        // Hold time is over, so no stale bit is left showing
        si = ~si;
        #40 cs_n = 1'b1;
    endtask
endmodule

// [flash_write_protection_test.sv]
// Purpose: Self-checking bench for the flash write-protection block
// Assumes: Host model makes sclk only inside frames
// Notes: Range decoding cases run from one table
`timescale 1ns/1ns
module flash_write_protection_test;
    import flash_wp_pkg::*;
    logic clk, srst, wp_n, array_done;
    wire logic sclk, cs_n, si;
    logic start, acc, rej, ready, deep, got, g_start;
    array_kind_t kind, g_kind;
    logic [SEC_W-1:0] lo, hi, g_lo, g_hi;
    logic [7:0] st_lo, st_hi, cfg;
    logic [BLOCK_COUNT-1:0] locks;
    int fails, n_compared, i;
    // Status low, status high, sector, erase expected to pass
    logic [26:0] tbl [13] = '{{8'h04, 8'h00, 10'h3f0, 1'b0}, {8'h04, 8'h00, 10'h3ef, 1'b1},
        {8'h04, 8'h40, 10'h3ef, 1'b0}, {8'h04, 8'h40, 10'h3f0, 1'b1},
        {8'h44, 8'h00, 10'h3ff, 1'b0}, {8'h44, 8'h00, 10'h3fe, 1'b1},
        {8'h24, 8'h00, 10'h00f, 1'b0}, {8'h24, 8'h00, 10'h010, 1'b1},
        {8'h1c, 8'h00, 10'h000, 1'b0}, {8'h00, 8'h40, 10'h200, 1'b0},
        {8'h1c, 8'h40, 10'h155, 1'b1}, {8'h58, 8'h00, 10'h3f8, 1'b0},
        {8'h58, 8'h00, 10'h3f7, 1'b1}};
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    spi_host_model i_host (.sclk(sclk), .cs_n(cs_n), .si(si));
    flash_write_protection i_dut (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n),
        .si(si), .wp_n(wp_n), .array_done(array_done), .array_start_q(start),
        .array_kind_q(kind), .array_lo_q(lo), .array_hi_q(hi), .cmd_accept_q(acc),
        .cmd_reject_q(rej), .status_lo_q(st_lo), .status_hi_q(st_hi), .config_q(cfg),
        .lock_bits_q(locks), .select_ready_q(ready), .deep_power_down_q(deep));
    task automatic finish_test;
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic frame(input logic [39:0] d, input int nbits, input logic exp);
        int k;
        i_host.send(d, nbits);
        got = 1'b0;
        for (k = 0; k < 40 && !got; k++) begin
            @(posedge clk);
            #1;
            got = (acc === 1'b1) || (rej === 1'b1);
            g_start = start;
            g_kind = kind;
            g_lo = lo;
            g_hi = hi;
        end
        if (!got) begin
            fails++;
            finish_test();
        end
        check("accept", acc, exp);
        repeat (12) @(posedge clk);
        if (st_lo[BUSY_BIT] === 1'b1) begin
            array_done <= 1'b1;
            @(posedge clk);
            array_done <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
    task automatic erase(input logic [SEC_W-1:0] sec, input logic exp);
        frame({OP_WRITE_LATCH_SET, 32'h0}, 8, 1'b1);
        frame({OP_SECTOR_ERASE, 2'b00, sec, 20'h0}, 32, exp);
        if (exp) begin
            check("start", g_start, 1'b1);
            check("range", {g_lo, g_hi}, {sec, sec});
            check("kind", g_kind, KIND_ERASE);
        end
    endtask
    task automatic wrsr(input logic [7:0] s_lo, input logic [7:0] s_hi);
        frame({OP_WRITE_LATCH_SET, 32'h0}, 8, 1'b1);
        frame({OP_WRITE_STATUS, s_lo, s_hi, 16'h0}, 24, 1'b1);
    endtask
    initial begin
        srst <= 1'b1;
        wp_n <= 1'b1;
        array_done <= 1'b0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        #1;
        check("status", {st_lo, st_hi}, 16'h0000);
        check("config", cfg, 8'h40);
        check("locks", locks, '1);
        check("ready", {ready, deep}, 2'b00);
        frame({OP_WRITE_LATCH_SET, 32'h0}, 8, 1'b0);
        for (i = 0; i < 2000 && ready !== 1'b1; i++)
            @(posedge clk);
        if (ready !== 1'b1) begin
            fails++;
            finish_test();
        end
        frame({OP_SECTOR_ERASE, 24'h005000, 8'h00}, 32, 1'b0);
        frame({OP_WRITE_LATCH_SET, 32'h0}, 8, 1'b1);
        check("latch", st_lo[WEL_BIT], 1'b1);
        frame({OP_SECTOR_ERASE, 24'h005000, 8'h00}, 30, 1'b0);
        check("latch kept", st_lo[WEL_BIT], 1'b1);
        erase(10'h005, 1'b1);
        check("latch", st_lo[WEL_BIT], 1'b0);
        for (i = 0; i < 13; i++) begin
            wrsr(tbl[i][26:19], tbl[i][18:11]);
            check("status", {st_lo, st_hi}, tbl[i][26:11]);
            erase(tbl[i][10:1], tbl[i][0]);
        end
        wp_n <= 1'b0;
        wrsr(8'h00, 8'h00);
        check("frozen", st_lo[7:2], 6'h16);
        wp_n <= 1'b1;
        wrsr(8'h00, 8'h00);
        check("status", st_lo, 8'h00);
        frame({OP_DEEP_DOWN, 32'h0}, 8, 1'b1);
        check("deep", deep, 1'b1);
        frame({OP_WRITE_LATCH_SET, 32'h0}, 8, 1'b0);
        frame({OP_DEEP_RELEASE, 32'h0}, 8, 1'b1);
        check("deep", deep, 1'b0);
        frame({OP_WRITE_LATCH_SET, 32'h0}, 8, 1'b1);
        frame({OP_WRITE_CONFIG, 8'h44, 24'h0}, 16, 1'b1);
        check("config", cfg, 8'h44);
        erase(10'h000, 1'b0);
        frame({OP_WRITE_LATCH_SET, 32'h0}, 8, 1'b1);
        frame({OP_BLOCK_UNLOCK, 32'h0}, 32, 1'b1);
        check("locks", locks, {{63{1'b1}}, 1'b0});
        erase(10'h000, 1'b1);
        frame({OP_WRITE_LATCH_SET, 32'h0}, 8, 1'b1);
        frame({OP_WRITE_LATCH_CLR, 32'h0}, 8, 1'b1);
        frame({OP_PAGE_PROGRAM, 32'h0}, 40, 1'b0);
        frame({OP_WRITE_LATCH_SET, 32'h0}, 8, 1'b1);
        frame({OP_BLOCK64_ERASE, 32'h01000000}, 32, 1'b0);
        frame({OP_PAGE_PROGRAM, 32'h00100000}, 40, 1'b1);
        check("program", {g_kind, g_lo, g_hi}, {KIND_PROGRAM, 10'h001, 10'h001});
        finish_test();
    end
endmodule
bind flash_write_protection flash_write_protection_monitor i_mon (.clk(clk), .srst(srst),
    .wp_n(wp_n), .array_start_q(array_start_q), .cmd_accept_q(cmd_accept_q),
    .cmd_reject_q(cmd_reject_q), .status_lo_q(status_lo_q), .status_hi_q(status_hi_q),
    .config_q(config_q), .lock_bits_q(lock_bits_q), .select_ready_q(select_ready_q),
    .deep_power_down_q(deep_power_down_q));
